// file: inc/monitor_regs_pkg.sv
// constants and types for the monitor control and voltage irq register bank
package monitor_regs_pkg;
  localparam logic [7:0] ADDR_TEST_A   = 8'h79;
  localparam logic [7:0] ADDR_TEST_RB  = 8'h7a;
  localparam logic [7:0] ADDR_TEST_B   = 8'h7b;
  localparam logic [7:0] ADDR_CONTROL  = 8'h7c;
  localparam logic [7:0] ADDR_VIRQ_EN  = 8'h7e;
  localparam logic [7:0] RST_TEST      = 8'h00;
  localparam logic [7:0] RST_CONTROL   = 8'h40;
  localparam logic [7:0] RST_VIRQ_EN   = 8'hec;
  localparam int BIT_LOW_POWER  = 0;
  localparam int BIT_MON_METHOD = 1;
  localparam int BIT_PIN_OE     = 2;
  localparam int BIT_GROUP_VOLT = 0;
  localparam int AVG_MSB        = 7;
  localparam int AVG_LSB        = 5;
  // rail index within the five-bit rail vector
  localparam int RAIL_2P5  = 0;
  localparam int RAIL_CORE = 1;
  localparam int RAIL_5V   = 2;
  localparam int RAIL_12V  = 3;
  localparam int RAIL_MAIN = 4;
  localparam logic [7:0] VIRQ_WRITABLE = 8'hed;
  localparam logic [7:0] AVG_CNT_1   = 8'h01;
  localparam logic [7:0] AVG_CNT_8   = 8'h08;
  localparam logic [7:0] AVG_CNT_16  = 8'h10;
  localparam logic [7:0] AVG_CNT_32  = 8'h20;
  localparam logic [7:0] AVG_CNT_128 = 8'h80;
  typedef enum logic [1:0] {
    AVG_FINE   = 2'b00,
    AVG_FAST   = 2'b01,
    AVG_EVEN   = 2'b10,
    AVG_STRONG = 2'b11
  } avg_mode_type;
endpackage

// file: src/monitor_control_voltage_irq_regs.sv
// register bank for monitor control, factory test and voltage interrupt enables
`timescale 1ns/100ps
module monitor_control_voltage_irq_regs (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port from the serial management front end
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // global lock
  input  wire logic       globalLock,
  // out-of-limit events per rail: 2p5, core, 5v, 12v, main
  input  wire logic [4:0] railEvent,
  // software clear of voltage status bits, one per rail
  input  wire logic [4:0] railStatusClear,
  // controls toward the measurement engine
  output logic            low_power_select,
  output logic            monitor_method_select,
  output logic            irq_pin_output_enable,
  output logic      [2:0] averaging_select,
  output logic      [7:0] remoteAverages,
  output logic      [7:0] otherAverages,
  // status and pin
  output logic      [4:0] railStatus,
  output logic            irqPin_n
);
  import monitor_regs_pkg::*;

  logic [7:0] testA;
  logic [7:0] testB;
  logic [7:0] monitor_control_bits;
  logic [7:0] voltIrqEnable;
  logic [4:0] railEnable;
  logic       writeOk;
  logic [4:0] next_railStatus;
  logic       next_irqPin_n;

  function automatic avg_mode_type avg_decode(input logic [2:0] code);
    if (code[2]) begin
      return AVG_STRONG;
    end else if (code[1]) begin
      return AVG_EVEN;
    end else if (code[0]) begin
      return AVG_FAST;
    end else begin
      return AVG_FINE;
    end
  endfunction

  // writes after lock are dropped silently, no error is reported
  assign writeOk = regWrite && !globalLock;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      testA <= RST_TEST;
      testB <= RST_TEST;
    end else if (writeOk) begin
      if (regAddr == ADDR_TEST_A) begin
        testA <= regWdata;
      end
      if (regAddr == ADDR_TEST_B) begin
        testB <= regWdata;
      end
    end
  end

  // bits 3 and 4 stored as written, readback has no side effect
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_control_bits <= RST_CONTROL;
    end else if (writeOk && regAddr == ADDR_CONTROL) begin
      monitor_control_bits <= regWdata;
    end
  end

  // reserved bits 1 and 4 hold zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      voltIrqEnable <= RST_VIRQ_EN;
    end else if (writeOk && regAddr == ADDR_VIRQ_EN) begin
      voltIrqEnable <= regWdata & VIRQ_WRITABLE;
    end
  end

  assign railEnable = {voltIrqEnable[7:5], voltIrqEnable[3:2]};
  assign low_power_select      = monitor_control_bits[BIT_LOW_POWER];
  assign monitor_method_select = monitor_control_bits[BIT_MON_METHOD];
  assign irq_pin_output_enable = monitor_control_bits[BIT_PIN_OE];
  assign averaging_select      = monitor_control_bits[AVG_MSB:AVG_LSB];

  // averaging counts registered so the engine sees a stable value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remoteAverages <= AVG_CNT_16;
      otherAverages  <= AVG_CNT_16;
    end else begin
      case (avg_decode(averaging_select))
        AVG_FINE: begin
          remoteAverages <= AVG_CNT_128;
          otherAverages  <= AVG_CNT_8;
        end
        AVG_FAST: begin
          remoteAverages <= AVG_CNT_16;
          otherAverages  <= AVG_CNT_1;
        end
        AVG_EVEN: begin
          remoteAverages <= AVG_CNT_16;
          otherAverages  <= AVG_CNT_16;
        end
        AVG_STRONG: begin
          remoteAverages <= AVG_CNT_32;
          otherAverages  <= AVG_CNT_32;
        end
        default: begin
          remoteAverages <= AVG_CNT_16;
          otherAverages  <= AVG_CNT_16;
        end
      endcase
    end
  end

  // a new event wins over a clear in the same cycle
  assign next_railStatus = (railStatus & ~railStatusClear) | (railEvent & railEnable);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      railStatus <= 5'h00;
    end else begin
      railStatus <= next_railStatus;
    end
  end

  assign next_irqPin_n = !(irq_pin_output_enable && voltIrqEnable[BIT_GROUP_VOLT]
                           && |(railStatus & railEnable));

  // pin registered to keep it glitch free
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPin_n <= 1'b1;
    end else begin
      irqPin_n <= next_irqPin_n;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        ADDR_TEST_A:  regRdata <= testA;
        ADDR_TEST_RB: regRdata <= {1'b0, testA[6:0]};
        ADDR_TEST_B:  regRdata <= testB;
        ADDR_CONTROL: regRdata <= monitor_control_bits;
        ADDR_VIRQ_EN: regRdata <= voltIrqEnable;
        default:      regRdata <= 8'h00;
      endcase
    end
  end

  // write-side checks: a taken write shows on the next edge, a locked one never does
  sequence s_ctrl_write;
    writeOk && regAddr == ADDR_CONTROL;
  endsequence

  sequence s_virq_write;
    writeOk && regAddr == ADDR_VIRQ_EN;
  endsequence

  a_lock_blocks_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && globalLock && regAddr == ADDR_CONTROL) |=> $stable(monitor_control_bits))
    else $error("control changed under lock");

  a_lock_blocks_virq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regWrite && globalLock) |=> $stable(voltIrqEnable) && $stable(testA) && $stable(testB))
    else $error("locked register changed");

  a_write_ctrl_takes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write |=> monitor_control_bits == $past(regWdata))
    else $error("control write lost");

  a_ctrl_mode_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write |=> low_power_select == $past(regWdata[BIT_LOW_POWER])
      && monitor_method_select == $past(regWdata[BIT_MON_METHOD]))
    else $error("low power or method bit misplaced");

  a_ctrl_pin_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write |=> irq_pin_output_enable == $past(regWdata[BIT_PIN_OE]))
    else $error("pin output enable misplaced");

  a_ctrl_avg_field: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ctrl_write |=> averaging_select == $past(regWdata[AVG_MSB:AVG_LSB]))
    else $error("averaging field misplaced");

  a_read_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regAddr == ADDR_CONTROL) |=> regRdata == $past(monitor_control_bits))
    else $error("control readback wrong");

  a_write_virq_takes: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_virq_write |=> voltIrqEnable == ($past(regWdata) & VIRQ_WRITABLE))
    else $error("voltage enable write lost");

  // reserved enable bits must never read back as one
  a_virq_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !voltIrqEnable[1] && !voltIrqEnable[4])
    else $error("reserved voltage enable bit set");

  a_read_virq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regAddr == ADDR_VIRQ_EN) |=> regRdata == $past(voltIrqEnable))
    else $error("voltage enable readback wrong");

  a_read_test_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regAddr == ADDR_TEST_A) |=> regRdata == $past(testA))
    else $error("test register readback wrong");

  // the readback port hides the top test bit
  a_test_rb_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (regAddr == ADDR_TEST_RB) |=> regRdata == {1'b0, $past(testA[6:0])})
    else $error("test mirror readback wrong");

  // checked on the first edge after any release, before a write can land
  a_reset_defaults: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> monitor_control_bits == RST_CONTROL && voltIrqEnable == RST_VIRQ_EN
      && railStatus == 5'h00 && irqPin_n && remoteAverages == AVG_CNT_16)
    else $error("register defaults wrong after reset");

  // averaging decoder, top bit first
  a_avg_top_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    averaging_select[2] |=> remoteAverages == AVG_CNT_32 && otherAverages == AVG_CNT_32)
    else $error("top averaging bit not 32");

  a_avg_fine_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (averaging_select == 3'b000) |=> remoteAverages == AVG_CNT_128 && otherAverages == AVG_CNT_8)
    else $error("code 000 decode wrong");

  a_avg_fast_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (averaging_select == 3'b001) |=> remoteAverages == AVG_CNT_16 && otherAverages == AVG_CNT_1)
    else $error("code 001 decode wrong");

  a_avg_even_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (averaging_select[2:1] == 2'b01)
    |=> remoteAverages == AVG_CNT_16 && otherAverages == AVG_CNT_16)
    else $error("code 01x decode wrong");

  // rail bits checked against the register layout, not the packed vector
  a_rail_map_2p5: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_2P5] && voltIrqEnable[2]) |=> railStatus[RAIL_2P5])
    else $error("2p5 rail enable misplaced");

  a_rail_map_core: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_CORE] && voltIrqEnable[3]) |=> railStatus[RAIL_CORE])
    else $error("core rail enable misplaced");

  a_rail_map_5v: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_5V] && voltIrqEnable[5]) |=> railStatus[RAIL_5V])
    else $error("5v rail enable misplaced");

  a_rail_map_12v: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_12V] && voltIrqEnable[6]) |=> railStatus[RAIL_12V])
    else $error("12v rail enable misplaced");

  a_rail_map_main: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_MAIN] && voltIrqEnable[7]) |=> railStatus[RAIL_MAIN])
    else $error("main rail enable misplaced");

  a_status_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_5V] && !railEnable[RAIL_5V] && !railStatus[RAIL_5V]) |=> !railStatus[RAIL_5V])
    else $error("disabled rail set status");

  a_status_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railEvent[RAIL_2P5] && railEnable[RAIL_2P5]) |=> railStatus[RAIL_2P5])
    else $error("enabled event lost");

  a_status_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railStatus[RAIL_CORE] && !railStatusClear[RAIL_CORE]) |=> railStatus[RAIL_CORE])
    else $error("status bit dropped without a clear");

  a_status_cleared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (railStatus[RAIL_MAIN] && railStatusClear[RAIL_MAIN] && !railEvent[RAIL_MAIN])
    |=> !railStatus[RAIL_MAIN])
    else $error("status bit survived its clear");

  a_pin_gated_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !irq_pin_output_enable |=> irqPin_n)
    else $error("pin active while output disabled");

  a_pin_group_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !voltIrqEnable[BIT_GROUP_VOLT] |=> irqPin_n)
    else $error("pin active with group off");

  a_pin_asserts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (irq_pin_output_enable && voltIrqEnable[BIT_GROUP_VOLT] && |(railStatus & railEnable))
    |=> !irqPin_n)
    else $error("pin not driven low");

  // pin low is only ever the echo of a path that was open one edge earlier
  a_pin_needs_path: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !irqPin_n |-> $past(irq_pin_output_enable && voltIrqEnable[BIT_GROUP_VOLT]))
    else $error("pin low without an open path");

  // an enabled event is taken, its status stands, and the open path pulls the pin
  sequence s_event_2p5;
    railEvent[RAIL_2P5] && railEnable[RAIL_2P5];
  endsequence

  sequence s_path_open_2p5;
    irq_pin_output_enable && voltIrqEnable[BIT_GROUP_VOLT] && railEnable[RAIL_2P5];
  endsequence

  a_event_to_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_event_2p5 ##1 s_path_open_2p5 |=> !irqPin_n)
    else $error("enabled event did not reach the pin");
endmodule

// file: verification/mgmt_host.sv
// management host model driving the register port of the bank
`timescale 1ns/100ps
module mgmt_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic            regWrite,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end
  // callers never aim this at test registers or set control bits 3 and 4
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    // scramble stale data so a late sample cannot pass by luck
    regWdata = ~d;
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    d = regRdata;
  endtask
endmodule

// file: verification/monitor_control_voltage_irq_regs_bench.sv
// self-checking bench for the monitor control and voltage irq register bank
`timescale 1ns/100ps
module monitor_control_voltage_irq_regs_bench;
  import monitor_regs_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       globalLock = 1'b0;
  logic [4:0] railEvent = 5'h00;
  logic [4:0] railStatusClear = 5'h00;
  logic       regWrite, lowPower, method, pinOe, irqPin_n;
  logic [7:0] regAddr, regWdata, regRdata, remAvg, othAvg, rdv;
  logic [2:0] avgSel;
  logic [15:0] expPair;
  logic [4:0] railStatus;
  int         fails = 0;
  int         cmp_count = 0;
  always #50 ref_clk = ~ref_clk;
  mgmt_host HOST (.clk(ref_clk), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  monitor_control_voltage_irq_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .globalLock(globalLock), .railEvent(railEvent), .railStatusClear(railStatusClear),
    .low_power_select(lowPower), .monitor_method_select(method),
    .irq_pin_output_enable(pinOe), .averaging_select(avgSel), .remoteAverages(remAvg),
    .otherAverages(othAvg), .railStatus(railStatus), .irqPin_n(irqPin_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    HOST.rd(a, rdv);
    chk($sformatf("reg%h", a), e, rdv);
  endtask
  // one-cycle event, then status, pin, and a full clear
  task automatic evt(input logic [4:0] ev, input logic [4:0] st, input logic pin);
    @(negedge ref_clk) railEvent = ev;
    @(negedge ref_clk) railEvent = 5'h00;
    chk("railStatus", {3'h0, st}, {3'h0, railStatus});
    @(negedge ref_clk) chk("irqPin_n", {7'h0, pin}, {7'h0, irqPin_n});
    railStatusClear = 5'h1f;
    @(negedge ref_clk) railStatusClear = 5'h00;
    @(negedge ref_clk) chk("irqPinIdle", 8'h01, {7'h0, irqPin_n});
  endtask
  function automatic logic [15:0] expAvg(input int c);
    if (c >= 4) return {AVG_CNT_32, AVG_CNT_32};
    if (c == 0) return {AVG_CNT_128, AVG_CNT_8};
    if (c == 1) return {AVG_CNT_16, AVG_CNT_1};
    return {AVG_CNT_16, AVG_CNT_16};
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    rdchk(ADDR_TEST_A, 8'h00);
    rdchk(ADDR_TEST_RB, 8'h00);
    rdchk(ADDR_TEST_B, 8'h00);
    rdchk(ADDR_CONTROL, 8'h40);
    rdchk(ADDR_VIRQ_EN, 8'hec);
    rdchk(8'h7d, 8'h00);
    chk("remAvgRst", AVG_CNT_16, remAvg);
    chk("othAvgRst", AVG_CNT_16, othAvg);
    for (int c = 0; c < 8; c++) begin
      HOST.wr(ADDR_CONTROL, {c[2:0], 5'h00});
      @(negedge ref_clk);
      expPair = expAvg(c);
      chk("avgSel", {5'h0, c[2:0]}, {5'h0, avgSel});
      chk("remAvg", expPair[15:8], remAvg);
      chk("othAvg", expPair[7:0], othAvg);
    end
    HOST.wr(ADDR_CONTROL, 8'h07);
    chk("ctlBits", 8'h07, {5'h0, pinOe, method, lowPower});
    rdchk(ADDR_CONTROL, 8'h07);
    HOST.wr(ADDR_VIRQ_EN, 8'hff);
    rdchk(ADDR_VIRQ_EN, 8'hed);
    for (int r = 0; r < 5; r++) evt(5'h01 << r, 5'h01 << r, 1'b0);
    HOST.wr(ADDR_VIRQ_EN, 8'hec);
    evt(5'h01, 5'h01, 1'b1);
    HOST.wr(ADDR_VIRQ_EN, 8'h01);
    evt(5'h1f, 5'h00, 1'b1);
    HOST.wr(ADDR_VIRQ_EN, 8'hed);
    HOST.wr(ADDR_CONTROL, 8'h00);
    evt(5'h01, 5'h01, 1'b1);
    @(negedge ref_clk) globalLock = 1'b1;
    HOST.wr(ADDR_CONTROL, 8'he3);
    HOST.wr(ADDR_VIRQ_EN, 8'h00);
    rdchk(ADDR_CONTROL, 8'h00);
    rdchk(ADDR_VIRQ_EN, 8'hed);
    @(negedge ref_clk) globalLock = 1'b0;
    HOST.wr(ADDR_CONTROL, 8'h80);
    rdchk(ADDR_CONTROL, 8'h80);
    // event and clear in one cycle: the event must win
    @(negedge ref_clk) railEvent = 5'h04;
    @(negedge ref_clk) railStatusClear = 5'h04;
    @(negedge ref_clk) railEvent = 5'h00;
    chk("setWins", 8'h04, {3'h0, railStatus});
    @(negedge ref_clk) railStatusClear = 5'h00;
    chk("railClear", 8'h00, {3'h0, railStatus});
    // mid-run reset must bring back the status, pin, remote average, control and enable defaults
    @(negedge ref_clk) railEvent = 5'h1f;
    @(negedge ref_clk) railEvent = 5'h00;
    chk("preReset", 8'h1f, {3'h0, railStatus});
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("rstStatus", 8'h00, {3'h0, railStatus});
    chk("rstPin", 8'h01, {7'h0, irqPin_n});
    chk("rstRemAvg", AVG_CNT_16, remAvg);
    rdchk(ADDR_CONTROL, 8'h40);
    rdchk(ADDR_VIRQ_EN, 8'hec);
    results;
  end
  // whole run is well under 400 cycles
  initial begin
    #100000;
    fails++;
    results;
  end
endmodule
